// ===== include/fp_load_pkg.sv
// Constants for the floating-point quad and single load unit
package fp_load_pkg;
  // Primary and extended opcodes
  localparam logic [5:0] OP_QUAD_UPD = 6'h39;
  localparam logic [5:0] OP_INDEXED = 6'h1F;
  localparam logic [5:0] OP_SINGLE = 6'h30;
  localparam logic [9:0] XO_QUAD_UPD_IDX = 10'h337;
  localparam logic [9:0] XO_QUAD_IDX = 10'h317;
  // Field positions, instruction bit 0 is word bit 31
  localparam int OPCD_LSB = 26;
  localparam int TARGET_LSB = 21;
  localparam int BASE_LSB = 16;
  localparam int XO_LSB = 1;
  localparam int QOFF_LSB = 2;
  localparam int QOFF_W = 14;
  localparam int DISP_W = 16;
  // Second doubleword of a quad pair
  localparam logic [31:0] QUAD_STEP = 32'h0000_0008;
  // Single to double exponent rebias, normal and subnormal
  localparam logic [10:0] EXP_REBIAS = 11'h380;
  localparam logic [10:0] EXP_SUB_BASE = 11'h36A;
  localparam logic [10:0] EXP_MAX = 11'h7FF;
  localparam int FRAC_PAD = 29;
  // Register offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] RETIRED_OFFSET = 12'h008;
  localparam logic [11:0] REFUSED_OFFSET = 12'h00C;
  // Field positions and reset values
  localparam int CTRL_QUAD_BIT = 0;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_QUAD_BIT = 1;
  localparam logic CTRL_QUAD_RESET = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== core/fp_quad_single_load_unit.sv
// Decoder and sequencer for quad-doubleword and single-precision FP loads
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - quad update offset is sign-extended field, times four
// - zero base field means offset alone
// - second doubleword at address+8 into next register
// - update forms write address to nonzero base
// - indexed address is base plus index register
// - extended codes select update-indexed or plain indexed
// - quad offset field with two zero low bits
// - quad loads only where the implementation supports them
// - no status or condition register changes, no record
// - single load uses sign-extended 16-bit displacement
// - single word widened and written to target
module fp_quad_single_load_unit #(
  parameter int ADDR_W = 32
) (
  input wire logic aclk, // Pipeline clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic instr_valid, // Instruction offered
  input wire logic [31:0] instr_word, // Instruction encoding
  input wire logic [31:0] base_value, // Contents of base_gpr
  input wire logic [31:0] index_value, // Contents of index_gpr
  output logic instr_ready, // Unit can take an instruction
  output logic done, // Instruction retired pulse
  output logic illegal, // Encoding refused pulse
  output logic mem_req, // Memory read request
  output logic [31:0] mem_addr, // Memory byte address
  output logic mem_word, // One word rather than a doubleword
  input wire logic mem_rvalid, // Read data returned
  input wire logic [63:0] mem_rdata, // Read data, word in low half
  output logic fpr_we, // Floating register write pulse
  output logic [4:0] fpr_waddr, // Floating register number
  output logic [63:0] fpr_wdata, // Floating register data
  output logic gpr_we, // Base register update pulse
  output logic [4:0] gpr_waddr, // Base register number
  output logic [31:0] gpr_wdata, // Updated base value
  input wire logic [11:0] awaddr, // AXI write address
  input wire logic [2:0] awprot, // AXI write protection, unused
  input wire logic awvalid, // AXI write address valid
  output logic awready, // AXI write address ready
  input wire logic [31:0] wdata, // AXI write data
  input wire logic [3:0] wstrb, // AXI write strobes
  input wire logic wvalid, // AXI write data valid
  output logic wready, // AXI write data ready
  output logic [1:0] bresp, // AXI write response
  output logic bvalid, // AXI write response valid
  input wire logic bready, // AXI write response ready
  input wire logic [11:0] araddr, // AXI read address
  input wire logic [2:0] arprot, // AXI read protection, unused
  input wire logic arvalid, // AXI read address valid
  output logic arready, // AXI read address ready
  output logic [31:0] rdata, // AXI read data
  output logic [1:0] rresp, // AXI read response
  output logic rvalid, // AXI read data valid
  input wire logic rready // AXI read data ready
);

  if (ADDR_W != 32)
  begin : width_check
    $error("Effective address must be 32 bits");
  end

  typedef enum logic [1:0] {IDLE, FIRST, SECOND} phase_type;

  typedef struct packed {
    phase_type phase;
    logic instr_ready;
    logic done;
    logic illegal;
    logic mem_req;
    logic [31:0] mem_addr;
    logic mem_word;
    logic fpr_we;
    logic [4:0] fpr_waddr;
    logic [63:0] fpr_wdata;
    logic gpr_we;
    logic [4:0] gpr_waddr;
    logic [31:0] gpr_wdata;
    logic quad;
    logic update;
    logic [4:0] target;
    logic [4:0] base;
    logic [31:0] ea;
    logic quad_enable;
    logic [31:0] retired;
    logic [31:0] refused;
    logic aw_full;
    logic w_full;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_type;

  state_type s_reg;
  state_type s_next;

  // Exact single to double conversion
  function automatic logic [63:0] widen(input logic [31:0] v);
    logic [7:0] e;
    logic [22:0] f;
    logic [22:0] m;
    logic [4:0] p;
    begin
      e = v[30:23];
      f = v[22:0];
      p = 5'h00;
      for (int i = 0; i < 23; i++)
      begin
        if (f[i])
        begin
          p = 5'(i);
        end
      end
      m = f << (5'h17 - p);
      if (e == 8'hFF)
      begin
        widen = {v[31], fp_load_pkg::EXP_MAX, f, {fp_load_pkg::FRAC_PAD{1'b0}}};
      end
      else if (e == 8'h00 && f == 23'h0)
      begin
        widen = {v[31], 63'h0};
      end
      else if (e == 8'h00)
      begin
        widen = {v[31], fp_load_pkg::EXP_SUB_BASE + {6'h00, p}, m,
                 {fp_load_pkg::FRAC_PAD{1'b0}}};
      end
      else
      begin
        widen = {v[31], fp_load_pkg::EXP_REBIAS + {3'h0, e}, f,
                 {fp_load_pkg::FRAC_PAD{1'b0}}};
      end
    end
  endfunction

  logic [5:0] opcd;
  logic [9:0] xo;
  logic [4:0] ra;
  logic [4:0] fp_target;
  logic [31:0] quad_off;
  logic [31:0] disp_off;
  logic [31:0] base_sum;
  logic is_qu;
  logic is_qux;
  logic is_qx;
  logic is_single;

  assign opcd = instr_word[fp_load_pkg::OPCD_LSB +: 6];
  assign xo = instr_word[fp_load_pkg::XO_LSB +: 10];
  assign ra = instr_word[fp_load_pkg::BASE_LSB +: 5];
  assign fp_target = instr_word[fp_load_pkg::TARGET_LSB +: 5];
  // sign-extend to 30 bits, append 00
  assign quad_off = {{(30 - fp_load_pkg::QOFF_W){instr_word[15]}},
                     instr_word[fp_load_pkg::QOFF_LSB +: fp_load_pkg::QOFF_W], 2'b00};
  assign disp_off = {{(32 - fp_load_pkg::DISP_W){instr_word[15]}},
                     instr_word[fp_load_pkg::DISP_W - 1:0]};
  assign base_sum = (ra == 5'h00) ? 32'h0 : base_value;
  // low two bits of the quad form must be 00
  assign is_qu = opcd == fp_load_pkg::OP_QUAD_UPD && instr_word[1:0] == 2'b00;
  // extended opcode selects the indexed form
  assign is_qux = opcd == fp_load_pkg::OP_INDEXED && xo == fp_load_pkg::XO_QUAD_UPD_IDX;
  assign is_qx = opcd == fp_load_pkg::OP_INDEXED && xo == fp_load_pkg::XO_QUAD_IDX;
  assign is_single = opcd == fp_load_pkg::OP_SINGLE;

  always_comb
  begin
    logic finish;
    logic clr_ret;
    logic clr_ref;
    logic [4:0] wr_target;
    finish = 1'b0;
    clr_ret = 1'b0;
    clr_ref = 1'b0;
    wr_target = s_reg.target;
    s_next = s_reg;
    s_next.done = 1'b0;
    s_next.illegal = 1'b0;
    s_next.fpr_we = 1'b0;
    s_next.gpr_we = 1'b0;
    unique case (s_reg.phase)
      IDLE:
      begin
        if (instr_valid)
        begin
          if (((is_qu || is_qux || is_qx) && s_reg.quad_enable) || is_single)
          begin
            s_next.phase = FIRST;
            s_next.instr_ready = 1'b0;
            s_next.mem_req = 1'b1;
            s_next.quad = !is_single;
            s_next.mem_word = is_single;
            s_next.update = is_qu || is_qux;
            s_next.target = fp_target;
            s_next.base = ra;
            if (is_qu)
              s_next.ea = base_sum + quad_off;
            else if (is_single)
              s_next.ea = base_sum + disp_off;
            else
              s_next.ea = base_sum + index_value;
            s_next.mem_addr = s_next.ea;
          end
          else
          begin
            s_next.illegal = 1'b1;
          end
        end
      end
      FIRST:
      begin
        if (mem_rvalid)
        begin
          s_next.fpr_we = 1'b1;
          s_next.fpr_waddr = s_reg.target;
          s_next.fpr_wdata = s_reg.mem_word ? widen(mem_rdata[31:0]) : mem_rdata;
          if (s_reg.quad)
          begin
            // next doubleword at address plus 8
            s_next.phase = SECOND;
            s_next.mem_addr = s_reg.ea + fp_load_pkg::QUAD_STEP;
          end
          else
          begin
            finish = 1'b1;
          end
        end
      end
      SECOND:
      begin
        if (mem_rvalid)
        begin
          // 31 wraps to 0 through 5-bit sum
          wr_target = s_reg.target + 5'h01;
          s_next.fpr_we = 1'b1;
          s_next.fpr_waddr = wr_target;
          s_next.fpr_wdata = mem_rdata;
          finish = 1'b1;
        end
      end
    endcase
    // only floating and base registers are ever written
    if (finish)
    begin
      s_next.phase = IDLE;
      s_next.mem_req = 1'b0;
      s_next.instr_ready = 1'b1;
      s_next.done = 1'b1;
      // write back address to nonzero base
      if (s_reg.update && s_reg.base != 5'h00)
      begin
        s_next.gpr_we = 1'b1;
        s_next.gpr_waddr = s_reg.base;
        s_next.gpr_wdata = s_reg.ea;
      end
    end

    // Write channel: address and data taken in either order
    if (awvalid && s_reg.awready)
    begin
      s_next.aw_full = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.w_full = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (s_reg.bvalid && bready)
      s_next.bvalid = 1'b0;
    if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid)
    begin
      s_next.aw_full = 1'b0;
      s_next.w_full = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = fp_load_pkg::RESP_OKAY;
      unique case (s_reg.aw_addr)
        fp_load_pkg::CTRL_OFFSET:
        begin
          if (s_reg.w_strb[0])
            s_next.quad_enable = s_reg.w_data[fp_load_pkg::CTRL_QUAD_BIT];
        end
        fp_load_pkg::STATUS_OFFSET: ;
        fp_load_pkg::RETIRED_OFFSET: clr_ret = 1'b1;
        fp_load_pkg::REFUSED_OFFSET: clr_ref = 1'b1;
        default: s_next.bresp = fp_load_pkg::RESP_SLVERR;
      endcase
    end
    s_next.awready = !s_next.aw_full;
    s_next.wready = !s_next.w_full;
    // Counting wins over a clear in the same cycle
    s_next.retired = (clr_ret ? 32'h0 : s_reg.retired) + {31'h0, finish};
    s_next.refused = (clr_ref ? 32'h0 : s_reg.refused) + {31'h0, s_next.illegal};

    // Read channel
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end
    if (arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = fp_load_pkg::RESP_OKAY;
      s_next.rdata = 32'h0;
      unique case (araddr)
        fp_load_pkg::CTRL_OFFSET:
          s_next.rdata[fp_load_pkg::CTRL_QUAD_BIT] = s_reg.quad_enable;
        fp_load_pkg::STATUS_OFFSET:
        begin
          s_next.rdata[fp_load_pkg::STATUS_BUSY_BIT] = s_reg.phase != IDLE;
          s_next.rdata[fp_load_pkg::STATUS_QUAD_BIT] = s_reg.quad;
        end
        fp_load_pkg::RETIRED_OFFSET: s_next.rdata = s_reg.retired;
        fp_load_pkg::REFUSED_OFFSET: s_next.rdata = s_reg.refused;
        default: s_next.rresp = fp_load_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg <= '0;
      s_reg.instr_ready <= 1'b1;
      s_reg.quad_enable <= fp_load_pkg::CTRL_QUAD_RESET;
      s_reg.awready <= 1'b1;
      s_reg.wready <= 1'b1;
      s_reg.arready <= 1'b1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign instr_ready = s_reg.instr_ready;
  assign done = s_reg.done;
  assign illegal = s_reg.illegal;
  assign mem_req = s_reg.mem_req;
  assign mem_addr = s_reg.mem_addr;
  assign mem_word = s_reg.mem_word;
  assign fpr_we = s_reg.fpr_we;
  assign fpr_waddr = s_reg.fpr_waddr;
  assign fpr_wdata = s_reg.fpr_wdata;
  assign gpr_we = s_reg.gpr_we;
  assign gpr_waddr = s_reg.gpr_waddr;
  assign gpr_wdata = s_reg.gpr_wdata;
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rresp = s_reg.rresp;
  assign rdata = s_reg.rdata;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  quad_offset_a: assert property (
    instr_valid && instr_ready && is_qu && s_reg.quad_enable && ra == 5'h00
    |=> mem_req && mem_addr == {{16{$past(instr_word[15])}}, $past(instr_word[15:2]), 2'b00})
    else $error("quad offset address wrong");
  base_add_a: assert property (
    instr_valid && instr_ready && is_qu && s_reg.quad_enable && ra != 5'h00
    |=> mem_addr == $past(base_value) + $past(quad_off))
    else $error("quad base sum wrong");
  second_word_a: assert property (
    s_reg.phase == FIRST && s_reg.quad && mem_rvalid
    |=> mem_req && mem_addr == s_reg.ea + 32'h8 && fpr_we && fpr_waddr == s_reg.target)
    else $error("second doubleword address wrong");
  base_update_a: assert property (
    gpr_we |-> done && gpr_waddr != 5'h00 && gpr_wdata == s_reg.ea)
    else $error("base update wrong");
  index_only_a: assert property (
    instr_valid && instr_ready && is_qx && s_reg.quad_enable && ra == 5'h00
    |=> mem_addr == $past(index_value))
    else $error("index address wrong");
  no_update_a: assert property (
    instr_valid && instr_ready && is_qx && s_reg.quad_enable |=> !gpr_we [*3])
    else $error("plain indexed updated base");
  low_bits_a: assert property (
    instr_valid && instr_ready && opcd == fp_load_pkg::OP_QUAD_UPD && instr_word[1:0] != 2'b00
    |=> illegal && !mem_req)
    else $error("bad quad encoding accepted");
  quad_off_a: assert property (
    instr_valid && instr_ready && (is_qu || is_qx || is_qux) && !s_reg.quad_enable
    |=> illegal && instr_ready)
    else $error("quad accepted while disabled");
  single_addr_a: assert property (
    instr_valid && instr_ready && is_single && ra != 5'h00
    |=> mem_word && mem_addr == $past(base_value) + $past(disp_off))
    else $error("single address wrong");
  single_write_a: assert property (
    s_reg.phase == FIRST && s_reg.mem_word && mem_rvalid
    |=> fpr_we && done && fpr_wdata[63] == $past(mem_rdata[31]))
    else $error("single result not written");
  widen_exact_a: assert property (
    s_reg.phase == FIRST && s_reg.mem_word && mem_rvalid && mem_rdata[30:23] != 8'h00
    && mem_rdata[30:23] != 8'hFF
    |=> fpr_wdata[62:52] == {3'h0, $past(mem_rdata[30:23])} + 11'h380
    && fpr_wdata[51:29] == $past(mem_rdata[22:0]) && fpr_wdata[28:0] == 29'h0)
    else $error("widening not exact");
endmodule

// ===== tb/load_mem_model.sv
// Behavioural data memory answering the load unit's read requests
`timescale 1ns/100ps
module load_mem_model (
  input wire logic aclk, // Pipeline clock
  input wire logic mem_req, // Read request
  input wire logic [31:0] mem_addr, // Byte address
  input wire logic [63:0] pat, // Data pattern from the bench
  input wire logic [1:0] max_wait, // Longest stall in cycles
  output logic mem_rvalid, // Read data returned
  output logic [63:0] mem_rdata // Read data
);
  logic [1:0] wait_cnt;
  logic [63:0] word;
  initial wait_cnt = 2'h0;
  // Upper half depends on address so each doubleword differs
  assign word = {mem_addr, 32'h0} ^ pat;
  assign mem_rvalid = mem_req && wait_cnt == 2'h0;
  // Inverted data while nothing is returned
  assign mem_rdata = mem_rvalid ? word : ~word;
  always @(posedge aclk)
  begin
    if (mem_req && mem_rvalid)
      wait_cnt <= 2'($urandom % (max_wait + 1));
    else if (mem_req && wait_cnt != 2'h0)
      wait_cnt <= wait_cnt - 2'h1;
  end
endmodule

// ===== tb/test_fp_quad_single_load_unit.sv
// Self-checking bench for the FP quad and single load unit
`timescale 1ns/100ps
module test_fp_quad_single_load_unit;
  logic aclk, aresetn, instr_valid, mem_rvalid, awvalid, wvalid, bready, arvalid, rready;
  logic instr_ready, done, illegal, mem_req, mem_word, fpr_we, gpr_we, qen;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] instr_word, base_value, index_value, mem_addr, gpr_wdata, wdata, rdata, d, w, r32;
  logic [63:0] mem_rdata, fpr_wdata, pat;
  logic [4:0] fpr_waddr, gpr_waddr, t, a;
  logic [11:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, max_wait, r;
  logic [31:0] sp [6];
  int mismatches, checked, cycles, retired, refused, i;
  fp_quad_single_load_unit DUT (.aclk(aclk), .aresetn(aresetn), .instr_valid(instr_valid),
    .instr_word(instr_word), .base_value(base_value), .index_value(index_value),
    .instr_ready(instr_ready), .done(done), .illegal(illegal), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_word(mem_word), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .fpr_we(fpr_we), .fpr_waddr(fpr_waddr), .fpr_wdata(fpr_wdata), .gpr_we(gpr_we),
    .gpr_waddr(gpr_waddr), .gpr_wdata(gpr_wdata), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  load_mem_model mem (.aclk(aclk), .mem_req(mem_req), .mem_addr(mem_addr), .pat(pat),
    .max_wait(max_wait), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (exp !== got)
    begin
      $display("FAIL %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      end_of_test;
    end
  end
  // Exact single to double widening
  function automatic logic [63:0] widen(input logic [31:0] s);
    logic [22:0] f;
    logic [10:0] e;
    f = s[22:0];
    e = 11'h380;
    if (s[30:23] == 8'hFF)
      return {s[31], 11'h7FF, f, 29'h0};
    if (s[30:23] != 8'h00)
      return {s[31], {3'h0, s[30:23]} + 11'h380, f, 29'h0};
    if (f == 23'h0)
      return {s[31], 63'h0};
    while (!f[22])
    begin
      f = f << 1;
      e = e - 11'h1;
    end
    return {s[31], e, f << 1, 29'h0};
  endfunction
  task axw(input logic [11:0] ad, input logic [31:0] dd, output logic [1:0] rs);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask
  task axr(input logic [11:0] ad, output logic [31:0] dd, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    dd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task issue(input logic [31:0] iw, input logic [31:0] b, input logic [31:0] x);
    logic [5:0] op;
    logic [4:0] ft, fa;
    logic [31:0] ea;
    logic [63:0] ex;
    logic q, s, upd, gseen;
    int nf, n;
    op = iw[31:26];
    ft = iw[25:21];
    fa = iw[20:16];
    q = qen && ((op == 6'h39 && iw[1:0] == 2'h0) ||
      (op == 6'h1F && (iw[10:1] == 10'h337 || iw[10:1] == 10'h317)));
    s = op == 6'h30;
    upd = q && fa != 5'h0 && (op == 6'h39 || iw[10:1] == 10'h337);
    ea = (fa != 5'h0 ? b : 32'h0) + (op == 6'h39 ? {{16{iw[15]}}, iw[15:2], 2'h0} :
      op == 6'h30 ? {{16{iw[15]}}, iw[15:0]} : x);
    nf = 0;
    gseen = 1'b0;
    @(posedge aclk);
    instr_word <= iw;
    base_value <= b;
    index_value <= x;
    instr_valid <= 1'b1;
    do @(posedge aclk); while (instr_ready !== 1'b1);
    instr_valid <= 1'b0;
    for (n = 0; n < 60; n++)
    begin
      #1;
      if (fpr_we === 1'b1)
      begin
        chk("fpr_waddr", 5'(ft + nf[4:0]), fpr_waddr);
        ex = s ? widen(pat[31:0]) : {32'(ea + nf * 8) ^ pat[63:32], pat[31:0]};
        chk("fpr_wdata", ex, fpr_wdata);
        nf++;
      end
      if (mem_req === 1'b1)
      begin
        chk("mem_addr", 32'(ea + nf * 8), mem_addr);
        chk("mem_word", s, mem_word);
      end
      if (gpr_we === 1'b1)
      begin
        gseen = 1'b1;
        chk("gpr_waddr", fa, gpr_waddr);
        chk("gpr_wdata", ea, gpr_wdata);
      end
      if (done === 1'b1 || illegal === 1'b1)
        break;
      @(posedge aclk);
    end
    chk("accepted", q || s, done);
    chk("fpr count", q ? 2 : s ? 1 : 0, nf);
    chk("base update", upd, gseen);
    retired += done;
    refused += illegal;
  endtask
  initial
  begin
    void'($urandom(32'hCD7B));
    {aresetn, instr_valid, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
    {instr_word, base_value, index_value, wdata, awaddr, araddr} = '0;
    wstrb = 4'hF;
    pat = 64'h0;
    max_wait = 2'h0;
    qen = 1'b1;
    sp = '{32'h3F800000, 32'h80000000, 32'h7F800000, 32'h7FA00001, 32'h00000001, 32'h00400000};
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Outputs held at their reset levels
    chk("reset outputs", 11'h780, {instr_ready, awready, wready, arready, mem_req, done,
      illegal, bvalid, rvalid, fpr_we, gpr_we});
    for (i = 0; i < 5; i++)
    begin
      axr(12'(i * 4), d, r);
      chk("reg reset", i == 0, d);
      chk("reg resp", i == 4 ? 2'h2 : 2'h0, r);
    end
    for (i = 0; i < 70; i++)
    begin
      r32 = $urandom;
      max_wait = 2'(i % 3);
      pat = {$urandom, i % 5 == 3 ? sp[(i / 5) % 6] : $urandom};
      t = i < 5 ? 5'h1F : r32[25:21];
      a = i % 4 == 0 ? 5'h0 : r32[20:16];
      // quad forms switched off for a stretch
      if (i == 40 || i == 55)
      begin
        qen = i == 55;
        axw(12'h000, {31'h0, qen}, r);
        chk("ctrl resp", 2'h0, r);
      end
      // Previous instruction was an accepted quad form
      if (i == 67)
      begin
        axr(12'h004, d, r);
        chk("status", 32'h2, d);
      end
      case (i % 5)
        0: w = {6'h39, t, a, r32[13:0], 2'h0};
        1: w = {6'h1F, t, a, r32[4:0], 10'h337, r32[5]};
        2: w = {6'h1F, t, a, r32[4:0], 10'h317, r32[5]};
        3: w = {6'h30, t, a, r32[15:0]};
        default:
          w = i % 2 ? {6'h39, t, a, r32[13:0], 2'h1} : {6'h1F, t, a, r32[4:0], 10'h257, 1'b0};
      endcase
      issue(w, $urandom, $urandom);
    end
    axr(12'h008, d, r);
    chk("retired", retired, d);
    axr(12'h00C, d, r);
    chk("refused", refused, d);
    axw(12'h008, 32'h0, r);
    chk("clear resp", 2'h0, r);
    axr(12'h008, d, r);
    chk("retired cleared", 32'h0, d);
    axw(12'h010, 32'h0, r);
    chk("unmapped write resp", 2'h2, r);
    end_of_test;
  end
endmodule
